//--- src/uart_ir_pkg.sv
package uart_ir_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_TXDATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RXDATA = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL0 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CTRL1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BRG_HI = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_BRG_LO = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_ADDR_MATCH = 8'h1C;
  // Control 0 fields
  localparam int C0_TX_EN = 0;
  localparam int C0_RX_ON = 1;
  localparam int C0_PAR_EN = 2;
  localparam int C0_PAR_ODD = 3;
  // Control 1 fields
  localparam int C1_MP_EN = 0;
  localparam int C1_MPMD_LO = 1;
  localparam int C1_MARKER = 3;
  localparam int C1_IR_EN = 4;
  localparam int C1_TXI_EN = 5;
  // Status 0 fields
  localparam int S0_AVAIL = 0;
  localparam int S0_TX_EMPTY = 1;
  localparam int S0_TX_IDLE = 2;
  localparam int S0_PAR_ERR = 3;
  localparam int S0_FRM_ERR = 4;
  localparam int S0_OVERRUN = 5;
  localparam int S0_RX_MARKER = 6;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;
  // Bit timing: sixteen baud ticks per bit
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] IR_HI_FIRST = 4'h7;
  localparam logic [3:0] IR_HI_LAST = 4'h9;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Multidrop modes
  localparam logic [1:0] MPMD_ALL = 2'h0;
  localparam logic [1:0] MPMD_ADDR_ONLY = 2'h1;
  localparam logic [1:0] MPMD_MATCH = 2'h2;
  localparam logic [1:0] MPMD_MATCH_DATA = 2'h3;
  // Clock and infrared rates
  localparam int CLK_HZ = 100_000_000;
  localparam int IR_BAUD_MIN = 9600;
  localparam int IR_BAUD_MAX = 115_200;
  localparam int DIV_IR_MIN = CLK_HZ / (16 * IR_BAUD_MIN);
  localparam int DIV_IR_MAX = CLK_HZ / (16 * IR_BAUD_MAX);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_EXTRA = 3'b011,
    ST_STOP = 3'b100
  } frame_state_t;
endpackage : uart_ir_pkg

//--- src/ir_encoder.sv
`timescale 1ns/10ps
module ir_encoder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic txd,
  input wire logic [3:0] phase,
  output logic ir_out
);
  import uart_ir_pkg::*;

  // A zero bit pulses high in the middle window of its sixteen ticks
  wire in_pulse = (phase >= IR_HI_FIRST) && (phase <= IR_HI_LAST);
  wire ir_d = enable && !txd && in_pulse;

  // Registered so the pin never glitches on phase decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_out <= 1'b0;
    end else begin
      ir_out <= ir_d;
    end
  end

  property p_ir_one_low;
    @(posedge aclk) disable iff (!aresetn)
    txd |=> !ir_out;
  endproperty
  a_ir_one_low: assert property (p_ir_one_low)
    else $error("infrared output high during a one bit");

  property p_ir_zero_shape;
    @(posedge aclk) disable iff (!aresetn)
    enable && !txd && (phase == IR_HI_FIRST) |=> ir_out;
  endproperty
  a_ir_zero_shape: assert property (p_ir_zero_shape)
    else $error("infrared pulse missing in a zero bit");

  property p_ir_zero_low;
    @(posedge aclk) disable iff (!aresetn)
    !txd && (phase < IR_HI_FIRST || phase > IR_HI_LAST) |=> !ir_out;
  endproperty
  a_ir_zero_low: assert property (p_ir_zero_low)
    else $error("infrared output high outside the pulse window");
endmodule : ir_encoder

//--- src/uart_ir.sv
// How it works
// - Transmit interrupt rises at once while enabled and holding register empty.
// - Written byte moves to shift register and is sent without software help.
// - Receiver accepts characters only while receive-on is set.
// - Even or odd parity only without multiprocessor mode; else marker bit.
// - Receive-available flag reads one while a valid byte is held.
// - Multiprocessor receive handling depends on two-bit multidrop mode.
// - Baud generator covers infrared rates 9600 to 115.2 kbaud.
// - Infrared bit rate equals clock over sixteen times the divisor.
// - Infrared output derives from transmit signal and baud clock.
// - Each encoded infrared bit lasts sixteen baud clocks.
// - A one bit keeps infrared output low for all sixteen clocks.
// - A zero bit is seven low, three high, six low clocks.
// - With infrared enabled the encoded output drives the transmit pin.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module uart_ir (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [uart_ir_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [uart_ir_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic tx_irq
);
  import uart_ir_pkg::*;

  // Offsets that answer OKAY; anything else gets SLVERR
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_TXDATA) || (a == OFF_RXDATA) ||
           (a == OFF_STATUS0) || (a == OFF_CTRL0) ||
           (a == OFF_CTRL1) || (a == OFF_BRG_HI) ||
           (a == OFF_BRG_LO) || (a == OFF_ADDR_MATCH);
  endfunction : is_mapped

  logic aw_hold_q, w_hold_q, w_lane_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [7:0] ctrl0_q, ctrl1_q, brg_hi_q, brg_lo_q, match_q;
  logic [7:0] rx_data_q, rd_byte;
  logic avail_q, par_err_q, frm_err_q, ovr_q, rx_mark_q;

  // Write side: address and data are caught in either order
  assign awready = !aw_hold_q;
  assign wready = !w_hold_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  wire wr_en = wr_fire && w_lane_q;
  wire wr_tx = wr_en && (aw_addr_q == OFF_TXDATA);
  wire wr_c0 = wr_en && (aw_addr_q == OFF_CTRL0);
  wire wr_c1 = wr_en && (aw_addr_q == OFF_CTRL1);
  wire wr_hi = wr_en && (aw_addr_q == OFF_BRG_HI);
  wire wr_lo = wr_en && (aw_addr_q == OFF_BRG_LO);
  wire wr_match = wr_en && (aw_addr_q == OFF_ADDR_MATCH);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
    end else begin
      if (awvalid && awready) aw_hold_q <= 1'b1;
      else if (wr_fire) aw_hold_q <= 1'b0;
      if (wvalid && wready) w_hold_q <= 1'b1;
      else if (wr_fire) w_hold_q <= 1'b0;
      if (wr_fire) bvalid_q <= 1'b1;
      else if (bready) bvalid_q <= 1'b0;
    end
  end

  // Payload captures need no reset; valid flags guard them
  always_ff @(posedge aclk) begin
    if (awvalid && awready) aw_addr_q <= awaddr;
    if (wvalid && wready) begin
      w_data_q <= wdata[7:0];
      w_lane_q <= wstrb[0];
    end
    if (wr_fire) bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
  end

  // Control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= RST_BYTE;
      ctrl1_q <= RST_BYTE;
      brg_hi_q <= RST_DIV[15:8];
      brg_lo_q <= RST_DIV[7:0];
      match_q <= RST_BYTE;
    end else begin
      if (wr_c0) ctrl0_q <= w_data_q;
      if (wr_c1) ctrl1_q <= w_data_q;
      if (wr_hi) brg_hi_q <= w_data_q;
      if (wr_lo) brg_lo_q <= w_data_q;
      if (wr_match) match_q <= w_data_q;
    end
  end

  wire tx_en = ctrl0_q[C0_TX_EN];
  wire rx_on = ctrl0_q[C0_RX_ON];
  wire mp_en = ctrl1_q[C1_MP_EN];
  wire par_en = ctrl0_q[C0_PAR_EN] && !mp_en;
  wire par_odd = ctrl0_q[C0_PAR_ODD];
  wire [1:0] mpmd = ctrl1_q[C1_MPMD_LO +: 2];
  wire ir_en = ctrl1_q[C1_IR_EN];
  wire extra_en = mp_en || par_en;

  // Baud generator: one tick per divisor clocks, sixteen ticks per bit
  logic [15:0] brg_cnt_q;
  wire [15:0] divisor = {brg_hi_q, brg_lo_q};
  wire tick = (brg_cnt_q == 16'h0000);
  wire [15:0] reload = (divisor == 16'h0000) ? 16'h0000 :
                       16'(divisor - 16'h0001);
  always_ff @(posedge aclk) begin
    if (!aresetn) brg_cnt_q <= 16'h0000;
    else brg_cnt_q <= tick ? reload : 16'(brg_cnt_q - 16'h0001);
  end

  // Transmitter: holding register feeds the shifter automatically
  frame_state_t tx_state_q;
  logic [3:0] tx_phase_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_hold_q, tx_shift_q;
  logic tx_full_q, tx_hold_mark_q, tx_extra_q, tx_has_extra_q;
  wire tx_load = (tx_state_q == ST_IDLE) && tx_full_q && tx_en;
  wire tx_bit_end = tick && (tx_phase_q == TICK_LAST);
  wire tx_par = ^tx_hold_q ^ par_odd;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_full_q <= 1'b0;
      tx_hold_q <= RST_BYTE;
      tx_hold_mark_q <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_hold_q <= w_data_q;
        tx_hold_mark_q <= ctrl1_q[C1_MARKER];
      end
      if (wr_tx) tx_full_q <= 1'b1;
      else if (tx_load) tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_q <= ST_IDLE;
      tx_phase_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_shift_q <= RST_BYTE;
      tx_extra_q <= 1'b0;
      tx_has_extra_q <= 1'b0;
    end else if (tx_load) begin
      tx_state_q <= ST_START;
      tx_phase_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_shift_q <= tx_hold_q;
      tx_extra_q <= mp_en ? tx_hold_mark_q : tx_par;
      tx_has_extra_q <= extra_en;
    end else if (tx_state_q != ST_IDLE) begin
      if (tick) tx_phase_q <= 4'(tx_phase_q + 4'h1);
      if (tx_bit_end) begin
        unique case (tx_state_q)
          ST_START: tx_state_q <= ST_DATA;
          ST_DATA: begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q <= 3'(tx_bit_q + 3'h1);
            if (tx_bit_q == BIT_LAST)
              tx_state_q <= tx_has_extra_q ? ST_EXTRA : ST_STOP;
          end
          ST_EXTRA: tx_state_q <= ST_STOP;
          ST_STOP: tx_state_q <= ST_IDLE;
          default: tx_state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Serial level from frame state; idle line is high
  logic txd;
  always_comb begin
    unique case (tx_state_q)
      ST_START: txd = 1'b0;
      ST_DATA: txd = tx_shift_q[0];
      ST_EXTRA: txd = tx_extra_q;
      default: txd = 1'b1;
    endcase
  end

  // Infrared encoder shares the transmit bit phase
  logic ir_out;
  ir_encoder u_ir_encoder (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(ir_en),
    .txd(txd),
    .phase(tx_phase_q),
    .ir_out(ir_out)
  );
  assign tx_pin = ir_en ? ir_out : txd;
  assign tx_irq = ctrl1_q[C1_TXI_EN] && !tx_full_q;

  // Receiver pin passes two flip-flops first
  logic rx_meta_q, rx_sync_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  frame_state_t rx_state_q;
  logic [3:0] rx_phase_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_shift_q;
  logic rx_extra_q, rx_sel_q;
  wire rx_mid = tick && (rx_phase_q == TICK_MID);
  wire rx_end = tick && (rx_phase_q == TICK_LAST);
  wire rx_done = (rx_state_q == ST_STOP) && rx_end;
  wire is_addr = mp_en && rx_extra_q;
  wire hit = (rx_shift_q == match_q);
  // Multidrop filter decides which bytes reach software
  logic keep;
  always_comb begin
    keep = 1'b1;
    if (mp_en) begin
      unique case (mpmd)
        MPMD_ALL: keep = 1'b1;
        MPMD_ADDR_ONLY: keep = is_addr;
        MPMD_MATCH: keep = is_addr ? hit : rx_sel_q;
        MPMD_MATCH_DATA: keep = !is_addr && rx_sel_q;
      endcase
    end
  end
  wire deliver = rx_done && keep;
  wire rd_rx = arvalid && arready && (araddr == OFF_RXDATA);
  wire rd_st = arvalid && arready && (araddr == OFF_STATUS0);

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_on) begin
      rx_state_q <= ST_IDLE;
      rx_phase_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_shift_q <= RST_BYTE;
      rx_extra_q <= 1'b0;
    end else begin
      if (tick) rx_phase_q <= 4'(rx_phase_q + 4'h1);
      unique case (rx_state_q)
        ST_IDLE: begin
          rx_phase_q <= 4'h0;
          if (!rx_sync_q) rx_state_q <= ST_START;
        end
        ST_START: begin
          if (rx_mid) begin
            rx_phase_q <= 4'h0; // Later samples fall mid-bit
            rx_bit_q <= 3'h0;
            rx_state_q <= rx_sync_q ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_end) begin
            rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
            rx_bit_q <= 3'(rx_bit_q + 3'h1);
            if (rx_bit_q == BIT_LAST)
              rx_state_q <= extra_en ? ST_EXTRA : ST_STOP;
          end
        end
        ST_EXTRA: begin
          if (rx_end) begin
            rx_extra_q <= rx_sync_q;
            rx_state_q <= ST_STOP;
          end
        end
        ST_STOP: if (rx_end) rx_state_q <= ST_IDLE;
        default: rx_state_q <= ST_IDLE;
      endcase
    end
  end

  // Received byte, flags; a new event wins over a clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_q <= RST_BYTE;
      avail_q <= 1'b0;
      par_err_q <= 1'b0;
      frm_err_q <= 1'b0;
      ovr_q <= 1'b0;
      rx_mark_q <= 1'b0;
      rx_sel_q <= 1'b0;
    end else begin
      if (rx_done && is_addr) rx_sel_q <= hit;
      if (deliver) begin
        rx_data_q <= rx_shift_q;
        rx_mark_q <= is_addr;
      end
      if (deliver) avail_q <= 1'b1;
      else if (rd_rx) avail_q <= 1'b0;
      if (deliver && par_en && (rx_extra_q != (^rx_shift_q ^ par_odd)))
        par_err_q <= 1'b1;
      else if (rd_st) par_err_q <= 1'b0;
      if (rx_done && !rx_sync_q) frm_err_q <= 1'b1;
      else if (rd_st) frm_err_q <= 1'b0;
      if (deliver && avail_q && !rd_rx) ovr_q <= 1'b1;
      else if (rd_st) ovr_q <= 1'b0;
    end
  end

  // Read side: one beat, answered the cycle after acceptance
  wire [7:0] status = {1'b0, rx_mark_q, ovr_q, frm_err_q, par_err_q,
                       (tx_state_q == ST_IDLE), !tx_full_q, avail_q};
  always_comb begin
    unique case (araddr)
      OFF_RXDATA: rd_byte = rx_data_q;
      OFF_STATUS0: rd_byte = status;
      OFF_CTRL0: rd_byte = ctrl0_q;
      OFF_CTRL1: rd_byte = ctrl1_q;
      OFF_BRG_HI: rd_byte = brg_hi_q;
      OFF_BRG_LO: rd_byte = brg_lo_q;
      OFF_ADDR_MATCH: rd_byte = match_q;
      default: rd_byte = RST_BYTE;
    endcase
  end
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  property p_tx_irq;
    @(posedge aclk) disable iff (!aresetn)
    ctrl1_q[C1_TXI_EN] && tx_load && !wr_tx && !wr_c1 |=> tx_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit interrupt missing while holding register empty");

  property p_auto_load;
    @(posedge aclk) disable iff (!aresetn)
    tx_load && !wr_tx |=> !tx_full_q && (tx_state_q == ST_START);
  endproperty
  a_auto_load: assert property (p_auto_load)
    else $error("held byte not moved into the shifter");

  property p_rx_gate;
    @(posedge aclk) disable iff (!aresetn)
    $rose(avail_q) |-> $past(rx_on);
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("byte received while receiver off");

  property p_marker_bit;
    @(posedge aclk) disable iff (!aresetn)
    tx_load && mp_en |=> tx_extra_q == $past(tx_hold_mark_q);
  endproperty
  a_marker_bit: assert property (p_marker_bit)
    else $error("ninth bit does not carry the address marker");

  property p_read_clears;
    @(posedge aclk) disable iff (!aresetn)
    rd_rx && !deliver |=> !avail_q ##1 rdata_q[7:0] == $past(rx_data_q, 2);
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("receive read did not clear availability");

  property p_avail_set;
    @(posedge aclk) disable iff (!aresetn)
    deliver |=> avail_q && (rx_data_q == $past(rx_shift_q));
  endproperty
  a_avail_set: assert property (p_avail_set)
    else $error("delivered byte not flagged as available");

  property p_baud_gap;
    @(posedge aclk) disable iff (!aresetn)
    tick && (divisor == 16'h0002) && $stable(divisor) |=> !tick ##1 tick;
  endproperty
  a_baud_gap: assert property (p_baud_gap)
    else $error("baud tick spacing differs from divisor");

  property p_ir_pin;
    @(posedge aclk) disable iff (!aresetn)
    ir_en && !$past(txd) && $past(tx_phase_q) == IR_HI_FIRST
      && $past(ir_en) |-> tx_pin;
  endproperty
  a_ir_pin: assert property (p_ir_pin)
    else $error("infrared pulse not on the transmit pin");
endmodule : uart_ir

//--- bench/serial_peer.sv
`timescale 1ns/10ps
module serial_peer (
  input wire logic aclk,
  input wire logic tx_line,
  output logic rx_line
);
  int bit_clks = 16;
  bit extra_on = 1'b0;
  bit mon_on = 1'b1;
  logic [8:0] got_q[$];

  // Line rests high between frames, as a real idle driver would
  initial rx_line = 1'b1;

  // One frame: start, eight data bits LSB first, optional ninth, stop
  task automatic send(input logic [7:0] b, input bit has_x, input bit x);
    logic [10:0] f;
    int n;
    f = has_x ? {1'b1, x, b, 1'b0} : {2'b11, b, 1'b0};
    n = has_x ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      rx_line <= f[i];
      repeat (bit_clks) @(posedge aclk);
    end
    rx_line <= 1'b1;
  endtask : send

  // Sample mid-bit so a slow or fast divisor shows as misaligned data
  always begin : mon
    logic [8:0] v;
    @(negedge tx_line);
    if (mon_on) begin
      v = '0;
      repeat (bit_clks / 2) @(posedge aclk);
      for (int i = 0; i < (extra_on ? 9 : 8); i++) begin
        repeat (bit_clks) @(posedge aclk);
        v[i] = tx_line;
      end
      got_q.push_back(v);
    end
  end
endmodule : serial_peer

//--- bench/uart_ir_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uart_ir_tb;
  import uart_ir_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rx_pin;
  logic awready, wready, bvalid, arready, rvalid, tx_pin, tx_irq, x, sel;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] b;
  logic [8:0] ga, ge;
  logic [8:0] exp_q[$];
  int n_fail = 0;
  int checks_done = 0;
  int i, m, k, h, n, len, t0;

  uart_ir u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_irq(tx_irq));
  serial_peer u_peer (.aclk(aclk), .tx_line(tx_pin), .rx_line(rx_pin));

  task automatic tally_and_finish();
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic hang();
    n_fail++;
    tally_and_finish();
  endtask : hang

  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask : tick

  // Both write channels offered together; bready stays high throughout
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        `CHK(bresp, er)
        return;
      end
    end
    hang();
  endtask : wr

  task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    for (int t = 0; t < 50; t++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        `CHK(rresp, er)
        return;
      end
    end
    hang();
  endtask : rd_reg

  task automatic st(input logic [7:0] mk, input logic [7:0] e);
    rd_reg(OFF_STATUS0, RESP_OKAY);
    `CHK(rd[7:0] & mk, e)
  endtask : st

  // Send one character and check whether the receiver kept it
  task automatic rx_one(input logic [7:0] d, input bit hx, input bit xb,
                        input bit av);
    u_peer.send(d, hx, xb);
    tick(8);
    st(8'h01, {7'h00, av});
    if (av) begin
      st(8'h40, {1'b0, hx && xb, 6'h00});
      rd_reg(OFF_RXDATA, RESP_OKAY);
      `CHK(rd, {24'h00_0000, d})
      st(8'h01, 8'h00);
    end
  endtask : rx_one

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Watchdog keeps a stuck handshake from running forever
  initial begin
    #900000;
    hang();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, arvalid} = 3'b000;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    k = $urandom(67);
    tick(6);
    aresetn <= 1'b1;
    tick(2);
    `CHK(tx_irq, 1'b0)
    st(8'h07, 8'h06);
    rd_reg(8'h20, RESP_SLVERR);
    `CHK(rd, 32'h0000_0000)
    wr(8'h20, 8'hFF, RESP_SLVERR);
    // A write with its low lane off must leave the register alone
    wstrb <= 4'h0;
    wr(OFF_ADDR_MATCH, 8'hFF, RESP_OKAY);
    wstrb <= 4'hF;
    rd_reg(OFF_ADDR_MATCH, RESP_OKAY);
    `CHK(rd, 32'h0000_0000)
    // Divisor goes in before anything is switched on
    wr(OFF_BRG_HI, 8'h00, RESP_OKAY);
    wr(OFF_BRG_LO, 8'h01, RESP_OKAY);
    rd_reg(OFF_BRG_LO, RESP_OKAY);
    `CHK(rd, 32'h0000_0001)
    wr(OFF_CTRL0, 8'h01, RESP_OKAY);
    wr(OFF_CTRL1, 8'h20, RESP_OKAY);
    `CHK(tx_irq, 1'b1)
    // Plain, even, odd, marker set, marker clear; two bytes back to back
    for (m = 0; m < 5; m++) begin
      u_peer.extra_on = (m != 0);
      wr(OFF_CTRL0, (m == 0) ? 8'h01 : (m == 1) ? 8'h05 : 8'h0D, RESP_OKAY);
      wr(OFF_CTRL1, (m == 3) ? 8'h29 : (m == 4) ? 8'h21 : 8'h20,
         RESP_OKAY);
      for (i = 0; i < 2; i++) begin
        b = 8'($urandom);
        x = (m == 0) ? 1'b0 : (m < 3) ? (^b ^ (m == 2)) : (m == 3);
        exp_q.push_back({x, b});
        wr(OFF_TXDATA, b, RESP_OKAY);
      end
      // Second byte waits in the holding register, so the request is down
      `CHK(tx_irq, 1'b0)
      for (i = 0; i < 1000 && u_peer.got_q.size() < 2; i++) tick(1);
      if (i == 1000) hang();
      while (exp_q.size() > 0) begin
        ga = u_peer.got_q.pop_front();
        ge = exp_q.pop_front();
        `CHK(ga, ge)
      end
      tick(20);
      `CHK(tx_irq, 1'b1)
    end
    // Receiver switched off, then on
    wr(OFF_CTRL1, 8'h00, RESP_OKAY);
    wr(OFF_CTRL0, 8'h00, RESP_OKAY);
    rx_one(8'($urandom), 1'b0, 1'b0, 1'b0);
    wr(OFF_CTRL0, 8'h02, RESP_OKAY);
    rx_one(8'($urandom), 1'b0, 1'b0, 1'b1);
    // Bad parity first, good parity second
    wr(OFF_CTRL0, 8'h06, RESP_OKAY);
    for (k = 0; k < 2; k++) begin
      b = 8'($urandom);
      u_peer.send(b, 1'b1, ^b ^ (k == 0));
      tick(8);
      st(8'h08, (k == 0) ? 8'h08 : 8'h00);
      rd_reg(OFF_RXDATA, RESP_OKAY);
    end
    // Each multidrop mode against match, data, other address, data
    wr(OFF_CTRL0, 8'h02, RESP_OKAY);
    wr(OFF_ADDR_MATCH, 8'h5A, RESP_OKAY);
    sel = 1'b0;
    for (m = 0; m < 4; m++) begin
      wr(OFF_CTRL1, 8'h01 | 8'(m << 1), RESP_OKAY);
      for (k = 0; k < 4; k++) begin
        b = (k == 0) ? 8'h5A : (k == 2) ? 8'hA5 : 8'($urandom);
        if (k % 2 == 0) sel = (b == 8'h5A);
        rx_one(b, 1'b1, k % 2 == 0, m == 0 || (m == 1 && k % 2 == 0) ||
               (m == 2 && sel) || (m == 3 && sel && k % 2 == 1));
      end
    end
    // Infrared at divisors 1, 2 and the fastest infrared rate; serial monitor off, transmitter on
    u_peer.mon_on = 1'b0;
    wr(OFF_CTRL0, 8'h01, RESP_OKAY);
    wr(OFF_CTRL1, 8'h10, RESP_OKAY);
    for (m = 0; m < 3; m++) begin
      k = (m == 2) ? DIV_IR_MAX : m + 1;
      wr(OFF_BRG_LO, 8'(k), RESP_OKAY);
      tick(2);
      `CHK(tx_pin, 1'b0)
      b = 8'($urandom);
      wr(OFF_TXDATA, b, RESP_OKAY);
      {h, n, len, t0} = '0;
      for (i = 0; i < 200 * k; i++) begin
        @(posedge aclk);
        if (tx_pin === 1'b1) begin
          if (len == 0 && n == 0) t0 = i;
          if (len == 0) begin
            `CHK((i - t0) % (16 * k), 0)
            n++;
          end
          len++;
          h++;
        end else if (len != 0) begin
          `CHK(len, 3 * k)
          len = 0;
        end
      end
      `CHK(n, 9 - $countones(b))
      `CHK(h, 3 * k * (9 - $countones(b)))
    end
    tally_and_finish();
  end
endmodule : uart_ir_tb
